// [verilog/bpm_pin_mux.v]
// pin routing multiplexer with its axi4-lite register file
`default_nettype none
`include "bpm_defines.vh"

module bpm_pin_mux (
    // clock and reset
    input  wire        clk,
    input  wire        resetn,
    // axi4-lite write address
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    // axi4-lite write data
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    // axi4-lite write response
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    // axi4-lite read address
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    // axi4-lite read data
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // host ownership outputs {ms, sd, sm, cf, disk}
    output reg  [4:0]  host_grant,
    // card host address line drive, lines 10..5
    input  wire [5:0]  card_addr_out,
    // counter unit channels 7..4
    input  wire [3:0]  counter_channel_pin_out,
    input  wire [3:0]  counter_channel_pin_dir,
    output reg  [3:0]  counter_channel_pin_in,
    // serial interface
    input  wire        sci_txd,
    output reg         sci_rxd,
    // upper route port pins
    input  wire [7:0]  upper_route_port_in,
    output reg  [7:0]  upper_route_port_out,
    output reg  [7:0]  upper_route_port_oe_n
);

    // =====================================================================
    // registers and decode wires
    reg  [7:0]  route_select_reg;   // configuration select
    reg  [6:0]  module_enable;      // module enable bits
    reg  [5:0]  card_addr_enable;   // card address line enables 10..5
    reg  [7:0]  gpio_out;           // gpio output data
    reg  [7:0]  gpio_dir;           // gpio direction, 1 drives
    reg  [7:0]  pin_meta;           // first synchroniser stage
    reg  [7:0]  pin_sync;           // second synchroniser stage
    reg  [7:0]  aw_addr;            // held write address
    reg         aw_held;            // write address captured
    reg  [31:0] w_data;             // held write data
    reg  [3:0]  w_strb;             // held write strobes
    reg         w_held;             // write data captured
    reg  [7:0]  next_port_out;      // pin value to drive
    reg  [7:0]  next_port_oe_n;     // pin enable to drive
    reg  [31:0] rd_value;           // read mux result
    reg         rd_hit;             // read address mapped
    wire [1:0]  config_code;        // decoded configuration
    wire [4:0]  grant;              // decoded ownership
    wire [4:0]  violation;          // forbidden hosts enabled
    wire        counter_route;      // counter owns bits 7..4
    wire        sci_route;          // serial owns bits 3..2
    wire [7:0]  ca_claim = {card_addr_enable & {6{grant[`BPM_EN_CF]}}, 2'b00}; // card owns pin
    wire [7:0]  ca_val   = {card_addr_out, 2'b00};            // card line values by pin
    wire [7:0]  cnt_val  = {counter_channel_pin_out, 4'h0};   // counter values by pin
    wire [7:0]  cnt_oe_n = {~counter_channel_pin_dir, 4'hF};  // counter enables by pin

    // byte-lane merge of a write into an 8-bit register
    function [7:0] lane0;
        input [7:0]  old_val;
        input [31:0] data;
        input [3:0]  strb;
        begin
            lane0 = strb[0] ? data[7:0] : old_val;
        end
    endfunction

    // =====================================================================
    // ownership decode
    bpm_route_decode u_decode (
        .route_select_reg (route_select_reg),
        .module_enable    (module_enable),
        .card_addr_enable (card_addr_enable),
        .config_code      (config_code),
        .host_grant       (grant),
        .host_violation   (violation),
        .counter_route    (counter_route),
        .sci_route        (sci_route)
    );

    // =====================================================================
    // two-stage synchroniser on the pins
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pin_meta <= 8'h00;
            pin_sync <= 8'h00;
        end else begin
            pin_meta <= upper_route_port_in;
            pin_sync <= pin_meta;
        end
    end

    // =====================================================================
    // upper port per-bit owner selection
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1) begin : g_pin
            always @* begin
                // default owner is gpio
                next_port_out[gi]  = gpio_out[gi];
                next_port_oe_n[gi] = ~gpio_dir[gi];
                if (ca_claim[gi]) begin
                    // card host address line claims the pin
                    next_port_out[gi]  = ca_val[gi];
                    next_port_oe_n[gi] = 1'b0;
                end else if (gi >= 4 && counter_route) begin
                    // counter channel on bits 7..4
                    next_port_out[gi]  = cnt_val[gi];
                    next_port_oe_n[gi] = cnt_oe_n[gi];
                end else if (gi == 3 && sci_route) begin
                    // serial transmit
                    next_port_out[gi]  = sci_txd;
                    next_port_oe_n[gi] = 1'b0;
                end else if (gi == 2 && sci_route) begin
                    // serial receive, pin is input
                    next_port_out[gi]  = 1'b0;
                    next_port_oe_n[gi] = 1'b1;
                end
            end
        end
    endgenerate

    // =====================================================================
    // output flops for pins, grants and module inputs
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            upper_route_port_out   <= 8'h00;
            upper_route_port_oe_n  <= 8'hFF;
            host_grant             <= 5'h00;
            sci_rxd                <= 1'b1;
            counter_channel_pin_in <= 4'h0;
        end else begin
            upper_route_port_out   <= next_port_out;
            upper_route_port_oe_n  <= next_port_oe_n;
            host_grant             <= grant;
            // idle high when the serial pins are not routed
            sci_rxd                <= sci_route ? pin_sync[2] : 1'b1;
            // channel inputs only seen while routed
            counter_channel_pin_in <= counter_route ? pin_sync[7:4] : 4'h0;
        end
    end

    // =====================================================================
    // write channel: address and data taken in either order
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s_axi_awready    <= 1'b0;
            s_axi_wready     <= 1'b0;
            s_axi_bvalid     <= 1'b0;
            s_axi_bresp      <= `BPM_RESP_OKAY;
            aw_addr          <= 8'h00;
            aw_held          <= 1'b0;
            w_data           <= 32'h0000_0000;
            w_strb           <= 4'h0;
            w_held           <= 1'b0;
            route_select_reg <= `BPM_RST_ROUTE;
            module_enable    <= `BPM_RST_ENABLE;
            card_addr_enable <= `BPM_RST_CARD_ADDR;
            gpio_out         <= `BPM_RST_GPIO;
            gpio_dir         <= `BPM_RST_GPIO;
        end else begin
            // ready high for one cycle when the channel is free
            s_axi_awready <= !aw_held && !s_axi_awready && !s_axi_bvalid && s_axi_awvalid;
            s_axi_wready  <= !w_held && !s_axi_wready && !s_axi_bvalid && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_addr <= s_axi_awaddr;
                aw_held <= 1'b1;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
                w_held <= 1'b1;
            end
            if (aw_held && w_held) begin
                // commit and answer once both halves are in
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= `BPM_RESP_OKAY;
                if ({aw_addr[7:2], 2'b00} == `BPM_OFS_ROUTE) begin
                    route_select_reg <= lane0(route_select_reg, w_data, w_strb);
                end else if ({aw_addr[7:2], 2'b00} == `BPM_OFS_ENABLE) begin
                    if (w_strb[0]) begin
                        module_enable <= w_data[6:0];
                    end
                end else if ({aw_addr[7:2], 2'b00} == `BPM_OFS_CARD_ADDR) begin
                    if (w_strb[0]) begin
                        card_addr_enable[2:0] <= w_data[7:5];
                    end
                    if (w_strb[1]) begin
                        card_addr_enable[5:3] <= w_data[10:8];
                    end
                end else if ({aw_addr[7:2], 2'b00} == `BPM_OFS_GPIO_OUT) begin
                    gpio_out <= lane0(gpio_out, w_data, w_strb);
                end else if ({aw_addr[7:2], 2'b00} == `BPM_OFS_GPIO_DIR) begin
                    gpio_dir <= lane0(gpio_dir, w_data, w_strb);
                end else if ({aw_addr[7:2], 2'b00} != `BPM_OFS_STATUS &&
                             {aw_addr[7:2], 2'b00} != `BPM_OFS_GPIO_IN) begin
                    // unmapped address
                    s_axi_bresp <= `BPM_RESP_SLVERR;
                end
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // =====================================================================
    // read mux
    always @* begin
        rd_value = 32'h0000_0000;
        rd_hit   = 1'b1;
        if ({s_axi_araddr[7:2], 2'b00} == `BPM_OFS_ROUTE) begin
            rd_value[7:0] = route_select_reg;
        end else if ({s_axi_araddr[7:2], 2'b00} == `BPM_OFS_ENABLE) begin
            rd_value[6:0] = module_enable;
        end else if ({s_axi_araddr[7:2], 2'b00} == `BPM_OFS_CARD_ADDR) begin
            rd_value[`BPM_CA_MSB:`BPM_CA_LSB] = card_addr_enable;
        end else if ({s_axi_araddr[7:2], 2'b00} == `BPM_OFS_GPIO_OUT) begin
            rd_value[7:0] = gpio_out;
        end else if ({s_axi_araddr[7:2], 2'b00} == `BPM_OFS_GPIO_DIR) begin
            rd_value[7:0] = gpio_dir;
        end else if ({s_axi_araddr[7:2], 2'b00} == `BPM_OFS_STATUS) begin
            rd_value[`BPM_ST_CFG_LSB+1:`BPM_ST_CFG_LSB]     = config_code;
            rd_value[`BPM_ST_GRANT_LSB+4:`BPM_ST_GRANT_LSB] = grant;
            rd_value[`BPM_ST_VIOL_LSB+4:`BPM_ST_VIOL_LSB]   = violation;
            rd_value[`BPM_ST_COUNTER]                       = counter_route;
            rd_value[`BPM_ST_SCI]                           = sci_route;
        end else if ({s_axi_araddr[7:2], 2'b00} == `BPM_OFS_GPIO_IN) begin
            rd_value[7:0] = pin_sync;
        end else begin
            rd_hit = 1'b0;
        end
    end

    // =====================================================================
    // read channel: one-cycle address accept, data the cycle after
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `BPM_RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_value;
                s_axi_rresp  <= rd_hit ? `BPM_RESP_OKAY : `BPM_RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule
`default_nettype wire

// [verilog/bpm_defines.vh]
// register map, field positions, reset values and configuration codes of the pin router
// =====================================================================
`ifndef BPM_DEFINES_VH
`define BPM_DEFINES_VH

// =====================================================================
// register byte offsets
`define BPM_OFS_ROUTE      8'h00
`define BPM_OFS_ENABLE     8'h04
`define BPM_OFS_CARD_ADDR  8'h08
`define BPM_OFS_GPIO_OUT   8'h0C
`define BPM_OFS_GPIO_DIR   8'h10
`define BPM_OFS_STATUS     8'h14
`define BPM_OFS_GPIO_IN    8'h18

// =====================================================================
// reset values
`define BPM_RST_ROUTE      8'h00
`define BPM_RST_ENABLE     7'h00
`define BPM_RST_CARD_ADDR  6'h00
`define BPM_RST_GPIO       8'h00

// =====================================================================
// route register values
`define BPM_ROUTE_DISK_CF  8'h10
`define BPM_ROUTE_CARDS    8'h00

// enable register bit positions
`define BPM_EN_DISK        0
`define BPM_EN_CF          1
`define BPM_EN_SM          2
`define BPM_EN_SD          3
`define BPM_EN_MS          4
`define BPM_EN_SCI         5
`define BPM_EN_COUNTER     6

// card address enable field: register bits 10..5 hold enables 10..5
`define BPM_CA_LSB         5
`define BPM_CA_MSB         10

// configuration codes
`define BPM_CFG_NONE       2'h0
`define BPM_CFG_DISK_CF    2'h1
`define BPM_CFG_DISK_CARDS 2'h2
`define BPM_CFG_CF_CARDS   2'h3

// host permit masks {ms, sd, sm, cf, disk}
`define BPM_PERMIT_NONE    5'h00
`define BPM_PERMIT_DISK_CF 5'h03
`define BPM_PERMIT_DISK    5'h1D
`define BPM_PERMIT_CF      5'h1E

// status register field positions
`define BPM_ST_CFG_LSB     0
`define BPM_ST_GRANT_LSB   2
`define BPM_ST_VIOL_LSB    7
`define BPM_ST_COUNTER     12
`define BPM_ST_SCI         13

// axi response codes
`define BPM_RESP_OKAY      2'h0
`define BPM_RESP_SLVERR    2'h2

`endif

// [verilog/bpm_route_decode.v]
// combinational decode of configuration, host ownership and upper port routing
`default_nettype none
`include "bpm_defines.vh"

module bpm_route_decode (
    // register inputs
    input  wire [7:0]  route_select_reg,
    input  wire [6:0]  module_enable,
    input  wire [5:0]  card_addr_enable,
    // decode results
    output reg  [1:0]  config_code,
    output reg  [4:0]  host_grant,
    output reg  [4:0]  host_violation,
    output reg         counter_route,
    output reg         sci_route
);

    reg [4:0] permit;  // hosts allowed in the chosen configuration
    reg       has_cf;  // configuration carries the card bridge

    // =====================================================================
    // configuration and ownership decode
    always @* begin
        config_code = `BPM_CFG_NONE;
        permit      = `BPM_PERMIT_NONE;
        if (route_select_reg == `BPM_ROUTE_DISK_CF) begin
            // disk plus card bridge
            config_code = `BPM_CFG_DISK_CF;
            permit      = `BPM_PERMIT_DISK_CF;
        end else if (route_select_reg == `BPM_ROUTE_CARDS) begin
            // the cf enable bit picks between the two card configurations
            if (module_enable[`BPM_EN_CF]) begin
                config_code = `BPM_CFG_CF_CARDS;
                permit      = `BPM_PERMIT_CF;
            end else begin
                config_code = `BPM_CFG_DISK_CARDS;
                permit      = `BPM_PERMIT_DISK;
            end
        end
        // only permitted, enabled hosts own their pins
        host_grant     = module_enable[4:0] & permit;
        // flag software that left a forbidden host on
        host_violation = module_enable[4:0] & ~permit;
        has_cf = (config_code == `BPM_CFG_DISK_CF) || (config_code == `BPM_CFG_CF_CARDS);
        // counter channels need address enables 10..7 all clear
        counter_route = has_cf && module_enable[`BPM_EN_COUNTER] &&
                        (card_addr_enable[5:2] == 4'h0);
        // serial pins need address enables 6..5 clear
        sci_route = has_cf && module_enable[`BPM_EN_SCI] &&
                    (card_addr_enable[1:0] == 2'h0);
    end

endmodule
`default_nettype wire

// [bench/bpm_pin_props.sv]
// assertion checker of the pin router port behaviour
`default_nettype none
module bpm_pin_props (
    // clock and reset
    input wire logic        clk,
    input wire logic        resetn,
    // register bus
    input wire logic        s_axi_awready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    // pins
    input wire logic [4:0]  host_grant,
    input wire logic [3:0]  counter_channel_pin_in,
    input wire logic        sci_rxd,
    input wire logic [7:0]  upper_route_port_in
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    // ========
    // bus handshakes
    property p_aw_pulse; s_axi_awready |=> !s_axi_awready; endproperty
    a_aw_pulse: assert property (p_aw_pulse) else $error("awready held");
    property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
    property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
    property p_ar_wait; $rose(s_axi_arvalid) |-> ##[1:4] s_axi_arready; endproperty
    a_ar_wait: assert property (p_ar_wait) else $error("read address not taken");
    property p_r_answer; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
    a_r_answer: assert property (p_r_answer) else $error("read answer late");
    // ========
    // ownership and routing
    property p_excl; host_grant[1:0] == 2'h3 |-> host_grant[4:2] == 3'h0; endproperty
    a_excl: assert property (p_excl) else $error("card host granted with disk and cf");
    property p_grant_time; $changed(host_grant) |-> $past(s_axi_bvalid); endproperty
    a_grant_time: assert property (p_grant_time) else $error("grant moved alone");
    property p_sci_rx; !sci_rxd |-> $past(upper_route_port_in[2], 3) == 1'b0; endproperty
    a_sci_rx: assert property (p_sci_rx) else $error("serial rx not from pin");
    property p_cnt_rx; counter_channel_pin_in[0] |-> $past(upper_route_port_in[4], 3);
    endproperty
    a_cnt_rx: assert property (p_cnt_rx) else $error("counter in not from pin");
endmodule
bind bpm_pin_mux bpm_pin_props bpm_pin_props_i (.clk(clk), .resetn(resetn),
    .s_axi_awready(s_axi_awready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
    .host_grant(host_grant), .counter_channel_pin_in(counter_channel_pin_in),
    .sci_rxd(sci_rxd), .upper_route_port_in(upper_route_port_in));
`default_nettype wire

// [bench/bpm_socket_model.sv]
// external socket model resolving the upper route port pins
`default_nettype none
module bpm_socket_model (
    // device side of the pins
    input wire logic [7:0]  port_out,
    input wire logic [7:0]  port_oe_n,
    // socket drive controls
    input wire logic [7:0]  ext_val,
    input wire logic [7:0]  ext_en,
    // resolved pin levels
    output var logic [7:0]  pin_level
);
    // device drive wins, then the socket, else the pull-up holds the pin high
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            pin_level[i] = !port_oe_n[i] ? port_out[i] : (ext_en[i] ? ext_val[i] : 1'b1);
        end
    end
endmodule
`default_nettype wire

// [bench/test_bridge_pin_config_mux.sv]
// self-checking bench of the pin routing multiplexer
`default_nettype none
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin err_count++; \
    $display("ERROR t=%0t got=%0h exp=%0h", $time, a, e); end end
module test_bridge_pin_config_mux;
    timeunit 1ns;
    timeprecision 1ps;
    // ========
    // stimulus and observed signals
    logic clk = 0, resetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [7:0] awaddr = 0, araddr = 0, ext_val = 0, ext_en = 0, pout, poe_n, pin, g, e;
    logic [31:0] wdata = 0, rdata;
    logic [3:0] wstrb = 0, cout = 0, cdir = 0, cin, c;
    logic [5:0] card_out = 0;
    logic txd = 0, awready, wready, bvalid, arready, rvalid, rxd;
    logic [1:0] bresp, rresp;
    logic [4:0] grant;
    int err_count = 0, cmp_count = 0;
    logic [33:0] exp_r[$];
    logic [1:0] exp_b[$];
    logic [33:0] r_note;
    logic [1:0] b_note;
    // config cases; rows 0 and 2 keep forbidden hosts off, others break it on purpose
    logic [7:0] rts[5] = '{8'h10, 8'h10, 8'h00, 8'h00, 8'h37};
    logic [6:0] ens[5] = '{7'h03, 7'h1F, 7'h1D, 7'h1F, 7'h1F};
    logic [31:0] sts[5] = '{32'h00D, 32'hE0D, 32'h076, 32'h0FB, 32'hF80};
    logic [4:0] grs[5] = '{5'h03, 5'h03, 5'h1D, 5'h1E, 5'h00};
    always #12.5 clk = ~clk;
    bpm_pin_mux bpm_pin_mux_i (.clk(clk), .resetn(resetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .host_grant(grant), .card_addr_out(card_out), .counter_channel_pin_out(cout),
        .counter_channel_pin_dir(cdir), .counter_channel_pin_in(cin), .sci_txd(txd),
        .sci_rxd(rxd), .upper_route_port_in(pin), .upper_route_port_out(pout),
        .upper_route_port_oe_n(poe_n));
    bpm_socket_model bpm_socket_model_i (.port_out(pout), .port_oe_n(poe_n),
        .ext_val(ext_val), .ext_en(ext_en), .pin_level(pin));
    // ========
    // monitor: each bus answer against the oldest note
    always @(posedge clk) begin
        if (rvalid && rready) begin
            r_note = exp_r.pop_front();
            `CHK({rresp, rdata}, r_note)
        end
        if (bvalid && bready) begin
            b_note = exp_b.pop_front();
            `CHK(bresp, b_note)
        end
    end
    // write: both halves offered together, each released when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                      input logic [1:0] r);
        bit aw_d, w_d;
        exp_b.push_back(r);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        aw_d = 0;
        w_d = 0;
        while (!(aw_d && w_d)) begin
            @(posedge clk);
            if (awready) begin aw_d = 1; awvalid <= 0; end
            if (wready) begin w_d = 1; wvalid <= 0; end
        end
        do @(posedge clk); while (!bvalid);
        bready <= 0;
    endtask
    // read: address held until taken, then wait for the answer
    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0);
        exp_r.push_back({r, d});
        @(posedge clk);
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        do @(posedge clk); while (!arready);
        arvalid <= 0;
        do @(posedge clk); while (!rvalid);
        rready <= 0;
    endtask
    task settle; repeat (4) @(posedge clk); endtask
    task done(input string n); $display("test %s finished", n); endtask
    task final_report;
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // ========
    // main sequence
    initial begin
        void'($urandom(68115));
        card_out <= 6'($urandom);
        repeat (12) @(posedge clk);
        resetn <= 1;
        for (int i = 0; i < 5; i++) rd(8'(i * 4), 32'h0);
        rd(8'h14, 32'h2);
        rd(8'h1C, 32'h0, 2'h2);
        done("reset");
        for (int i = 0; i < 5; i++) begin
            wr(8'h04, {25'h0, ens[i]}, 4'h1, 2'h0);
            wr(8'h00, {24'h0, rts[i]}, 4'h1, 2'h0);
            rd(8'h14, sts[i]);
            settle();
            `CHK(grant, grs[i])
        end
        done("configs");
        c = 4'($urandom) | 4'h1;
        cout <= c;
        cdir <= 4'hF;
        txd <= 1'($urandom);
        ext_en <= 8'h04;
        wr(8'h00, 32'h0, 4'h1, 2'h0);
        wr(8'h04, 32'h62, 4'h1, 2'h0);
        rd(8'h14, 32'h300B);
        settle();
        `CHK({pout[7:3], poe_n}, {c, txd, 8'h07})
        `CHK({cin, rxd}, {c, 1'b0})
        wr(8'h08, 32'h400, 4'h3, 2'h0);
        rd(8'h14, 32'h200B);
        wr(8'h08, 32'h20, 4'h3, 2'h0);
        rd(8'h08, 32'h20);
        rd(8'h14, 32'h100B);
        settle();
        `CHK(rxd, 1'b1)
        `CHK({pout[3:2], poe_n[3:2]}, {1'b0, card_out[0], 2'b10})
        done("routing");
        g = 8'($urandom);
        e = 8'($urandom);
        ext_val <= e;
        ext_en <= 8'hF0;
        wr(8'h04, 32'h0, 4'h1, 2'h0);
        wr(8'h10, 32'hFF, 4'h1, 2'h0);
        wr(8'h0C, {24'h0, g}, 4'h1, 2'h0);
        settle();
        `CHK({pout, poe_n}, {g, 8'h00})
        rd(8'h18, {24'h0, g});
        wr(8'h10, 32'h0F, 4'h1, 2'h0);
        settle();
        rd(8'h18, {24'h0, e[7:4], g[3:0]});
        wr(8'h14, 32'hFFFF, 4'hF, 2'h0);
        wr(8'h1C, 32'hFFFF, 4'hF, 2'h2);
        rd(8'h14, 32'h2);
        done("gpio");
        final_report();
    end
    // watchdog far beyond the expected run
    initial begin
        repeat (5000) @(posedge clk);
        err_count++;
        final_report();
    end
endmodule
`default_nettype wire
